// >>> verilog/lhc_hardwire_ctrl.sv
// Contract
// - request input gates all other hardwired inputs
// - select all low: run input enables emission
// - any select high: enter programming mode
// - program starts on run input rising edge
// - select value chooses the stored program
// - nonzero program: power from running program
// - zero program plus analog enable: analog power
// - internal control input enables pc control
// - alarm reset rising edge clears alarm latch
// - guide input level drives guide beam indicator
// - analog enable input enables analog setpoint
// - select lines form binary, first is lsb
// - running output high while program executes
// - feedback output high once request received
// - alarm reset high clears abnormal termination
//
// Chosen here: the register addresses and the Avalon-MM slave port.
module lhc_hardwire_ctrl
  import lhc_pkg::*;
(
  input  wire logic                  mclk,                    // system clock, 250 mhz
  input  wire logic                  rst_n,                   // synchronous reset, active low
  // hardwired pins from the machine controller
  input  wire logic                  request_in,              // laser request
  input  wire logic                  run_enable_in,           // enable or program start
  input  wire logic                  internal_control_en_in,  // pc control enable
  input  wire logic                  alarm_reset_in,          // alarm reset
  input  wire logic                  guide_light_in,          // guide light on
  input  wire logic                  analog_control_en_in,    // analog setpoint enable
  input  wire logic [LHC_PSEL_W-1:0] program_select_in,       // program number, lsb first
  // events from the laser core and program engine
  input  wire logic                  alarm_event,             // fault raises the alarm
  input  wire logic                  program_done,            // program ended normally
  input  wire logic                  program_abort,           // program ended abnormally
  // hardwired status pins
  output logic                       request_feedback_out,    // request accepted
  output logic                       program_running_out,     // program executing
  output logic                       abnormal_termination_out,// abnormal program end
  // controls toward the laser core
  output logic                       emission_enable,         // plain emission enable
  output logic                       program_start,           // one-cycle start pulse
  output logic [LHC_PSEL_W-1:0]      program_number,          // program to execute
  output logic                       power_from_program,      // setpoint from program
  output logic                       power_from_analog,       // setpoint from analog
  output logic                       pc_control_en,           // pc path enabled
  output logic                       analog_input_en,         // analog input enabled
  output logic                       guide_beam_on,           // guide beam indicator
  output logic                       alarm_latched,           // latched alarm bit
  // avalon-mm slave
  input  wire logic [3:0]            avs_address,             // byte address
  input  wire logic                  avs_read,                // read request
  input  wire logic                  avs_write,               // write request
  input  wire logic [LHC_DATA_W-1:0] avs_writedata,           // write data
  input  wire logic [3:0]            avs_byteenable,          // byte lanes
  output logic      [LHC_DATA_W-1:0] avs_readdata,            // read data
  output logic                       avs_waitrequest          // stall, low to complete
);

  // one packed word holds all
  // flops; next_st is built
  // combinationally and loaded
  // on every edge
  // whole state of the decoder
  typedef struct packed {
    logic                  req_fb;      // accepted request
    logic                  running;     // program executing
    logic                  abnormal;    // abnormal end latch
    logic                  alarm;       // alarm latch
    logic                  emission;    // plain emission enable
    logic                  start;       // start pulse
    logic [LHC_PSEL_W-1:0] pnum;        // latched program number
    logic                  src_prog;    // program power source
    logic                  src_ana;     // analog power source
    logic                  pc_en;       // pc control
    logic                  ana_en;      // analog input enable
    logic                  guide;       // guide beam
    logic                  run_prev;    // run level last cycle
    logic                  arst_prev;   // alarm reset last cycle
    logic                  port_en;     // software port enable
    logic                  wait_r;      // waitrequest flop
    logic [LHC_DATA_W-1:0] rdata;       // read data flop
  } lhc_state_s;

  lhc_state_s st;       // registered state
  lhc_state_s next_st;  // next state

  // pins are asynchronous; only
  // second-stage copies are read
  // synchronised pins
  logic [LHC_LVL_W-1:0]  lvl_sync;   // single level pins
  logic [LHC_PSEL_W-1:0] psel_sync;  // program select pins

  // decode helpers
  // any program select line high means programming mode
  function automatic logic lhc_is_prog(input logic [LHC_PSEL_W-1:0] sel);
    return |sel;
  endfunction

  // rising edge between two samples
  function automatic logic lhc_rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // bundle order matches the
  // unpack: bit 0 is request
  // level pins ride through one synchroniser bundle
  lhc_sync #(
    .W (LHC_LVL_W)
  ) u_sync_lvl (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({analog_control_en_in, guide_light_in, alarm_reset_in,
             internal_control_en_in, run_enable_in, request_in}),
    .dout  (lvl_sync)
  );

  // program select lines in their own bundle
  lhc_sync #(
    .W (LHC_PSEL_W)
  ) u_sync_psel (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (program_select_in),
    .dout  (psel_sync)
  );

  // pin levels after stage two
  // named views of the synchronised pins
  logic                  s_req;    // request
  logic                  s_run;    // run enable
  logic                  s_pc;     // internal control
  logic                  s_arst;   // alarm reset
  logic                  s_guide;  // guide light
  logic                  s_ana;    // analog enable

  // unpack the level bundle
  always_comb begin
    s_req   = lvl_sync[0];
    s_run   = lvl_sync[1];
    s_pc    = lvl_sync[2];
    s_arst  = lvl_sync[3];
    s_guide = lvl_sync[4];
    s_ana   = lvl_sync[5];
  end

  // a transfer ends at the edge
  // that sees waitrequest low;
  // writes act only there
  // bus request decode
  logic bus_req;   // read or write pending
  logic bus_done;  // completes at this edge
  logic wr_ctrl;   // write to control, low lane
  assign bus_req  = avs_read | avs_write;
  assign bus_done = bus_req & ~st.wait_r;
  assign wr_ctrl  = bus_done & avs_write & (avs_address == LHC_OFS_CTRL) & avs_byteenable[0];

  // next-state logic for the decoder and the bus slave
  always_comb begin
    logic                  gate;      // request accepted and port on
    logic                  pmode;     // programming mode
    logic                  run_rise;  // run enable rising edge
    logic                  arst_rise; // alarm reset rising edge
    logic                  alarm_clr; // any alarm clear
    logic                  abort_clr; // any abnormal clear
    logic [LHC_DATA_W-1:0] rd;        // read mux result
    gate      = 1'b0;
    pmode     = 1'b0;
    run_rise  = 1'b0;
    arst_rise = 1'b0;
    alarm_clr = 1'b0;
    abort_clr = 1'b0;
    rd        = LHC_WORD_RST;
    next_st   = st;

    // request gates the pin decodes below, not the edge history; software may shut the port
    gate  = s_req & st.port_en;
    // program number read as binary, first select line lowest
    pmode = gate & lhc_is_prog(psel_sync);

    // edges with request low
    // are lost
    // edges only count while the request is present
    run_rise  = gate & lhc_rise(s_run, st.run_prev);
    arst_rise = gate & lhc_rise(s_arst, st.arst_prev);

    // history runs while gated:
    // run held across request
    // rise is no edge
    // edge history follows the pins every cycle
    next_st.run_prev  = s_run;
    next_st.arst_prev = s_arst;

    // acceptance feedback toward the controller
    next_st.req_fb = gate;

    // plain emission enable only outside programming mode
    next_st.emission = gate & ~lhc_is_prog(psel_sync) & s_run;

    // one cycle, whatever pins do
    // start pulse defaults low
    next_st.start = 1'b0;

    // request drop never stops
    // a running program
    // program end from the engine clears the running flag
    if (program_done | program_abort) begin
      next_st.running = 1'b0;
    end
    // rising run edge in programming mode starts the program
    if (pmode & run_rise & ~st.running) begin
      next_st.running = 1'b1;
      next_st.start   = 1'b1;
      next_st.pnum    = psel_sync;
    end

    // analog enable with nonzero
    // number: status flags it,
    // program source kept
    // power source: program wins over analog when nonzero
    next_st.src_prog = pmode;
    next_st.src_ana  = gate & ~lhc_is_prog(psel_sync) & s_ana;

    // synced pins, gated by request
    // plain level controls
    next_st.pc_en  = gate & s_pc;
    next_st.guide  = gate & s_guide;
    next_st.ana_en = gate & s_ana;

    // hold time not timed here;
    // first synced edge clears
    // alarm latch: pin edge or software clears, new alarm wins
    alarm_clr = arst_rise | (wr_ctrl & avs_writedata[LHC_CTRL_ALARM_CLR]);
    if (alarm_clr) begin
      next_st.alarm = 1'b0;
    end
    if (alarm_event) begin
      next_st.alarm = 1'b1;
    end

    // this clear is a level
    // abnormal end: cleared while reset pin high, new abort wins
    abort_clr = (gate & s_arst) | (wr_ctrl & avs_writedata[LHC_CTRL_ABORT_CLR]);
    if (abort_clr) begin
      next_st.abnormal = 1'b0;
    end
    if (program_abort) begin
      next_st.abnormal = 1'b1;
    end

    // port disable acts like
    // request low
    // control register write
    if (wr_ctrl) begin
      next_st.port_en = avs_writedata[LHC_CTRL_PORT_EN];
    end

    // read data taken at the
    // edge dropping waitrequest
    // read mux; unmapped offsets read zero
    unique case (avs_address)
      LHC_OFS_CTRL: begin
        rd[LHC_CTRL_PORT_EN] = st.port_en;
      end
      LHC_OFS_STATUS: begin
        rd[LHC_ST_REQ_FB]    = st.req_fb;
        rd[LHC_ST_PROG_MODE] = st.src_prog;
        rd[LHC_ST_RUNNING]   = st.running;
        rd[LHC_ST_ABNORMAL]  = st.abnormal;
        rd[LHC_ST_ALARM]     = st.alarm;
        rd[LHC_ST_EMISSION]  = st.emission;
        rd[LHC_ST_SRC_PROG]  = st.src_prog;
        rd[LHC_ST_SRC_ANA]   = st.src_ana;
        rd[LHC_ST_PC_EN]     = st.pc_en;
        rd[LHC_ST_GUIDE]     = st.guide;
        rd[LHC_ST_ANA_EN]    = st.ana_en;
        rd[LHC_ST_CONFLICT]  = st.src_prog & st.ana_en;
        rd[LHC_ST_PNUM_LSB +: LHC_PSEL_W] = st.pnum;
      end
      LHC_OFS_INPUTS: begin
        rd[LHC_IN_REQ]   = s_req;
        rd[LHC_IN_RUN]   = s_run;
        rd[LHC_IN_PC]    = s_pc;
        rd[LHC_IN_ARST]  = s_arst;
        rd[LHC_IN_GUIDE] = s_guide;
        rd[LHC_IN_ANA]   = s_ana;
        rd[LHC_IN_PSEL +: LHC_PSEL_W] = psel_sync;
      end
      default: begin
        rd = LHC_WORD_RST;
      end
    endcase

    // two cycles per transfer;
    // next may follow at once
    // waitrequest: drop for one cycle, then rise again on completion
    if (bus_done) begin
      next_st.wait_r = 1'b1;
      next_st.rdata  = LHC_WORD_RST;
    end else if (bus_req) begin
      next_st.wait_r = 1'b0;
      next_st.rdata  = avs_read ? rd : LHC_WORD_RST;
    end else begin
      next_st.wait_r = 1'b1;
      next_st.rdata  = LHC_WORD_RST;
    end
  end

  // reset: port on, bus idle
  // with waitrequest high
  // single state register with synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st         <= '0;
      st.port_en <= LHC_PORT_EN_RST;
      st.pnum    <= LHC_PNUM_RST;
      st.wait_r  <= 1'b1;
      st.rdata   <= LHC_WORD_RST;
    end else begin
      st <= next_st;
    end
  end

  // no logic between flops
  // and pins
  // outputs straight from the state flops
  assign request_feedback_out     = st.req_fb;
  assign program_running_out      = st.running;
  assign abnormal_termination_out = st.abnormal;
  assign emission_enable          = st.emission;
  assign program_start            = st.start;
  assign program_number           = st.pnum;
  assign power_from_program       = st.src_prog;
  assign power_from_analog        = st.src_ana;
  assign pc_control_en            = st.pc_en;
  assign analog_input_en          = st.ana_en;
  assign guide_beam_on            = st.guide;
  assign alarm_latched            = st.alarm;
  assign avs_readdata             = st.rdata;
  assign avs_waitrequest          = st.wait_r;

endmodule

// >>> verilog/lhc_pkg.sv
// shared constants for the hardwired remote-control input decoder
package lhc_pkg;

  // register byte offsets on the avalon slave
  localparam logic [3:0] LHC_OFS_CTRL   = 4'h0;  // control
  localparam logic [3:0] LHC_OFS_STATUS = 4'h4;  // decoded state
  localparam logic [3:0] LHC_OFS_INPUTS = 4'h8;  // synchronised pins

  // control register fields
  localparam int LHC_CTRL_PORT_EN   = 0;  // hardwire port enable
  localparam int LHC_CTRL_ALARM_CLR = 1;  // write one to clear alarm
  localparam int LHC_CTRL_ABORT_CLR = 2;  // write one to clear abnormal end

  // control reset value: port enabled
  localparam logic LHC_PORT_EN_RST = 1'b1;

  // status register fields
  localparam int LHC_ST_REQ_FB    = 0;   // request accepted
  localparam int LHC_ST_PROG_MODE = 1;   // programming mode
  localparam int LHC_ST_RUNNING   = 2;   // program running
  localparam int LHC_ST_ABNORMAL  = 3;   // abnormal termination
  localparam int LHC_ST_ALARM     = 4;   // latched alarm
  localparam int LHC_ST_EMISSION  = 5;   // plain emission enable
  localparam int LHC_ST_SRC_PROG  = 6;   // power from program
  localparam int LHC_ST_SRC_ANA   = 7;   // power from analog input
  localparam int LHC_ST_PC_EN     = 8;   // pc control enabled
  localparam int LHC_ST_GUIDE     = 9;   // guide beam on
  localparam int LHC_ST_ANA_EN    = 10;  // analog input enabled
  localparam int LHC_ST_CONFLICT  = 11;  // analog enable with program set
  localparam int LHC_ST_PNUM_LSB  = 16;  // running program number

  // inputs register fields
  localparam int LHC_IN_REQ   = 0;  // request level
  localparam int LHC_IN_RUN   = 1;  // run enable level
  localparam int LHC_IN_PC    = 2;  // internal control level
  localparam int LHC_IN_ARST  = 3;  // alarm reset level
  localparam int LHC_IN_GUIDE = 4;  // guide light level
  localparam int LHC_IN_ANA   = 5;  // analog enable level
  localparam int LHC_IN_PSEL  = 8;  // program select lsb

  // widths
  localparam int LHC_PSEL_W = 7;   // program select lines
  localparam int LHC_LVL_W  = 6;   // single level inputs
  localparam int LHC_DATA_W = 32;  // bus data width

  // reset values
  localparam logic [LHC_PSEL_W-1:0] LHC_PNUM_RST = 7'h00;
  localparam logic [LHC_DATA_W-1:0] LHC_WORD_RST = 32'h0000_0000;

endpackage

// >>> verilog/lhc_sync.sv
// two-flop synchroniser for a bundle of pins
module lhc_sync #(
  parameter int W = 1  // bundle width
) (
  input  wire logic         mclk,   // system clock
  input  wire logic         rst_n,  // synchronous reset, active low
  input  wire logic [W-1:0] din,    // asynchronous pins
  output logic      [W-1:0] dout    // synchronised copy
);

  // both stages in one state word
  typedef struct packed {
    logic [W-1:0] meta;  // first stage, read only by stage two
    logic [W-1:0] safe;  // second stage
  } lhc_sync_s;

  lhc_sync_s st;       // registered state
  lhc_sync_s next_st;  // next state

  // shift pins through the two stages
  always_comb begin
    next_st      = st;
    next_st.meta = din;
    next_st.safe = st.meta;
  end

  // register the stages
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.safe;  // only the second stage leaves

endmodule

// >>> test/lhc_hardwire_ctrl_properties.sv
// port-level checks for the hardwired input decoder
module lhc_hardwire_ctrl_chk
  import lhc_pkg::*;
(
  input wire logic                  mclk,                      // clock
  input wire logic                  rst_n,                     // reset
  input wire logic                  request_in,                // pin
  input wire logic                  run_enable_in,             // pin
  input wire logic                  internal_control_en_in,    // pin
  input wire logic                  guide_light_in,            // pin
  input wire logic                  analog_control_en_in,      // pin
  input wire logic [LHC_PSEL_W-1:0] program_select_in,         // pins
  input wire logic                  program_done,              // engine
  input wire logic                  program_abort,             // engine
  input wire logic                  request_feedback_out,      // out
  input wire logic                  program_running_out,       // out
  input wire logic                  abnormal_termination_out,  // out
  input wire logic                  emission_enable,           // out
  input wire logic                  program_start,             // out
  input wire logic [LHC_PSEL_W-1:0] program_number,            // out
  input wire logic                  power_from_program,        // out
  input wire logic                  power_from_analog,         // out
  input wire logic                  pc_control_en,             // out
  input wire logic                  analog_input_en,           // out
  input wire logic                  guide_beam_on              // out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_cnt;  // edges since reset release
  logic       ok;      // pin pipeline free of reset values
  // saturating count, three edges fill the pipeline
  always_ff @(posedge mclk) begin
    if (!rst_n) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  end
  assign ok = (up_cnt == 2'h3);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_REQ_FB: assert property (ok |-> request_feedback_out == $past(request_in, 3))
    else $error("feedback does not track request");
  AST_GUIDE: assert property (ok |-> guide_beam_on == ($past(guide_light_in, 3) && $past(request_in, 3)))
    else $error("guide beam wrong");
  AST_PC: assert property (ok |-> pc_control_en == ($past(internal_control_en_in, 3) && $past(request_in, 3)))
    else $error("pc control wrong");
  AST_ANA_EN: assert property (ok |-> analog_input_en == ($past(analog_control_en_in, 3) && $past(request_in, 3)))
    else $error("analog enable wrong");
  AST_EMIS: assert property (ok |-> emission_enable == ($past(request_in, 3) && $past(run_enable_in, 3)
    && $past(program_select_in, 3) == 7'h00)) else $error("emission enable wrong");
  AST_SRC_PROG: assert property (ok |-> power_from_program == ($past(request_in, 3)
    && $past(program_select_in, 3) != 7'h00)) else $error("program source wrong");
  AST_SRC_ANA: assert property (ok |-> power_from_analog == ($past(request_in, 3) && $past(analog_control_en_in, 3)
    && $past(program_select_in, 3) == 7'h00)) else $error("analog source wrong");
  AST_START: assert property (ok && $rose(program_start) |-> program_number == $past(program_select_in, 3))
    else $error("program number wrong at start");
  AST_PULSE: assert property (program_start |=> !program_start && program_running_out)
    else $error("start pulse wrong");
  AST_END: assert property (program_running_out && (program_done || program_abort) |=> !program_running_out)
    else $error("running did not end");
  AST_ABORT: assert property (program_running_out && program_abort |=> abnormal_termination_out)
    else $error("abnormal end not flagged");
endmodule

bind lhc_hardwire_ctrl lhc_hardwire_ctrl_chk i_chk (.mclk, .rst_n, .request_in, .run_enable_in,
  .internal_control_en_in, .guide_light_in, .analog_control_en_in, .program_select_in, .program_done,
  .program_abort, .request_feedback_out, .program_running_out, .abnormal_termination_out, .emission_enable,
  .program_start, .program_number, .power_from_program, .power_from_analog, .pc_control_en,
  .analog_input_en, .guide_beam_on);

// >>> test/lhc_ctrl_model.sv
// machine controller driving the hardwired pins
module lhc_ctrl_model #(
  parameter int HOLD = 16  // alarm reset hold, shortened
) (
  input  wire logic       mclk,                    // clock
  input  wire logic       rst_n,                   // reset
  input  wire logic       running,                 // program running
  input  wire logic [5:0] cmd,                     // ana,guide,arst,pc,run,req
  input  wire logic [6:0] cmd_sel,                 // program wanted
  output logic            request_in,              // pin
  output logic            run_enable_in,           // pin
  output logic            internal_control_en_in,  // pin
  output logic            alarm_reset_in,          // pin
  output logic            guide_light_in,          // pin
  output logic            analog_control_en_in,    // pin
  output logic [6:0]      program_select_in        // pins
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_cnt;  // alarm reset cycles left
  // pins follow the wanted levels one edge later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {request_in, run_enable_in, internal_control_en_in} <= 3'h0;
      {alarm_reset_in, guide_light_in, analog_control_en_in} <= 3'h0;
      program_select_in <= 7'h00;
      hold_cnt <= 0;
    end else begin
      request_in <= cmd[0];
      internal_control_en_in <= cmd[2];
      guide_light_in <= cmd[4];
      analog_control_en_in <= cmd[5];
      // run drops only after the program ended
      if (cmd[1]) run_enable_in <= 1'b1;
      else if (!running) run_enable_in <= 1'b0;
      program_select_in <= cmd[5] ? 7'h00 : cmd_sel;
      // alarm reset held high for the whole hold
      if (cmd[3] && !alarm_reset_in) begin
        alarm_reset_in <= 1'b1;
        hold_cnt <= HOLD;
      end else if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
      else alarm_reset_in <= cmd[3];
    end
  end
endmodule

// >>> test/test_lhc_hardwire_ctrl.sv
// self-checking bench for the hardwired input decoder
module test_lhc_hardwire_ctrl;
  import lhc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, alarm_event, program_done, program_abort;  // drives
  logic [5:0]  cmd;                                      // wanted pin levels
  logic [6:0]  cmd_sel, program_select_in, program_number;  // program numbers
  logic        request_in, run_enable_in, internal_control_en_in, alarm_reset_in;  // pins
  logic        guide_light_in, analog_control_en_in;    // pins
  logic        request_feedback_out, program_running_out, abnormal_termination_out;  // status
  logic        emission_enable, program_start, power_from_program, power_from_analog;  // controls
  logic        pc_control_en, analog_input_en, guide_beam_on, alarm_latched;  // controls
  logic [3:0]  avs_address;                             // bus
  logic        avs_read, avs_write, avs_waitrequest;    // bus
  logic [31:0] avs_writedata, avs_readdata, d;          // bus data
  int          n_mismatch, tests_run;                   // counters
  lhc_ctrl_model i_model (.mclk, .rst_n, .running(program_running_out), .cmd, .cmd_sel, .request_in,
    .run_enable_in, .internal_control_en_in, .alarm_reset_in, .guide_light_in, .analog_control_en_in,
    .program_select_in);
  lhc_hardwire_ctrl i_dut (.mclk, .rst_n, .request_in, .run_enable_in, .internal_control_en_in,
    .alarm_reset_in, .guide_light_in, .analog_control_en_in, .program_select_in, .alarm_event,
    .program_done, .program_abort, .request_feedback_out, .program_running_out, .abnormal_termination_out,
    .emission_enable, .program_start, .program_number, .power_from_program, .power_from_analog,
    .pc_control_en, .analog_input_en, .guide_beam_on, .alarm_latched, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest);
  // clock, 4 ns period
  always #2 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] w);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= w;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    chk(avs_waitrequest, 0, "bus answer");
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic t_levels;
    for (int r = 0; r < 2; r++) begin
      cmd <= {5'b11010, r[0]};
      settle(6);
      chk(request_feedback_out, r[0], "feedback");
      chk(guide_beam_on, r[0], "guide");
      chk(pc_control_en, r[0], "pc control");
      chk(analog_input_en, r[0], "analog enable");
      chk(power_from_analog, r[0], "analog source");
    end
    cmd <= 6'b000011;
    settle(6);
    chk(guide_beam_on, 0, "guide off");
    chk(emission_enable, 1, "plain emission");
    cmd <= 6'b000001;
    cmd_sel <= 7'h05;
    settle(6);
    chk(power_from_program, 1, "program source");
    chk(power_from_analog, 0, "no analog source");
    $display("test levels done");
  endtask
  task automatic t_program(input logic abort);
    int n = 0;
    cmd <= 6'b000001;
    cmd_sel <= 7'h45;
    settle(6);
    cmd <= 6'b000011;
    do begin
      @(posedge mclk);
      n++;
    end while (program_start !== 1'b1 && n < 20);
    chk(n < 20, 1, "start pulse");
    chk(program_number, 7'h45, "program number");
    chk(emission_enable, 0, "no plain emission");
    cmd <= 6'b000001;
    settle(4);
    chk(program_running_out, 1, "running held");
    if (abort) program_abort <= 1'b1;
    else program_done <= 1'b1;
    @(posedge mclk);
    program_abort <= 1'b0;
    program_done <= 1'b0;
    settle(2);
    chk(program_running_out, 0, "running ended");
    chk(abnormal_termination_out, abort, "abnormal flag");
    $display("test program done");
  endtask
  task automatic t_alarm;
    alarm_event <= 1'b1;
    @(posedge mclk);
    alarm_event <= 1'b0;
    bus(1'b0, LHC_OFS_STATUS, 32'h0000_0000);
    chk(d[LHC_ST_ALARM], 1, "alarm set");
    cmd <= 6'b001001;
    @(posedge mclk);
    cmd <= 6'b000001;
    settle(26);
    chk(alarm_latched, 0, "alarm cleared");
    chk(abnormal_termination_out, 0, "abnormal cleared");
    alarm_event <= 1'b1;
    @(posedge mclk);
    alarm_event <= 1'b0;
    bus(1'b1, LHC_OFS_CTRL, 32'h0000_0003);
    bus(1'b0, LHC_OFS_STATUS, 32'h0000_0000);
    chk(d[LHC_ST_ALARM], 0, "alarm cleared by bus");
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(d, 32'h0000_0000, "unmapped read");
    bus(1'b0, LHC_OFS_INPUTS, 32'h0000_0000);
    chk(d[LHC_IN_REQ], 1, "synced request");
    chk(d[LHC_IN_PSEL +: LHC_PSEL_W], 7'h45, "synced select");
    $display("test alarm done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    {mclk, rst_n, alarm_event, program_done, program_abort, avs_read, avs_write} = 7'h00;
    cmd = 6'h00;
    cmd_sel = 7'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_levels;
    t_program(1'b0);
    t_program(1'b1);
    t_alarm;
    wrap_up;
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    wrap_up;
  end
endmodule
